/* File: dcd_defines.svh */
`ifndef DCD_DEFINES_SVH
`define DCD_DEFINES_SVH

// ==========================================================
// register byte offsets
`define DCD_OFS_SRC       8'h00
`define DCD_OFS_DST       8'h04
`define DCD_OFS_NEXT      8'h08
`define DCD_OFS_CTRL      8'h0C
`define DCD_OFS_CFG       8'h10
`define DCD_OFS_STATUS    8'h14
`define DCD_OFS_MASK      8'h18

// ==========================================================
// reset values
`define DCD_RST_WORD      32'h0000_0000
`define DCD_RST_STATUS    2'h0

// ==========================================================
// next pointer fields
`define DCD_NEXT_MSB      31
`define DCD_NEXT_LSB      2

// ==========================================================
// control word fields
`define DCD_CTRL_IRQ_EN   31
`define DCD_CTRL_DST_INC  27
`define DCD_CTRL_SRC_INC  26
`define DCD_CTRL_DW_MSB   23
`define DCD_CTRL_DW_LSB   21
`define DCD_CTRL_SW_MSB   20
`define DCD_CTRL_SW_LSB   18
`define DCD_CTRL_DB_MSB   17
`define DCD_CTRL_DB_LSB   15
`define DCD_CTRL_SB_MSB   14
`define DCD_CTRL_SB_LSB   12
`define DCD_CTRL_CNT_MSB  11
`define DCD_CTRL_CNT_LSB  0
`define DCD_CTRL_WMASK    32'h8CFF_FFFF

// ==========================================================
// configuration and status fields
`define DCD_CFG_EN        0
`define DCD_CFG_CEIM      1
`define DCD_ST_END        0
`define DCD_ST_ERR        1

// ==========================================================
// descriptor layout: word index of each field
`define DCD_DESC_SRC      2'h0
`define DCD_DESC_DST      2'h1
`define DCD_DESC_NEXT     2'h2
`define DCD_DESC_CTRL     2'h3

`endif

/* File: dcd_pkg.sv */
package dcd_pkg;

  // ========================================================
  // channel sequencer states
  typedef enum logic [4:0]
  {
    ST_IDLE  = 5'h01,
    ST_READ  = 5'h02,
    ST_WRITE = 5'h04,
    ST_END   = 5'h08,
    ST_FETCH = 5'h10
  } dcd_state_t;

  // ========================================================
  // access width codes
  typedef enum logic [2:0]
  {
    WD_BYTE = 3'h0,
    WD_HALF = 3'h1,
    WD_WORD = 3'h2
  } dcd_width_t;

endpackage

/* File: dcd_beat_decode.sv */
// ==========================================================
// burst code to beat count
module dcd_beat_decode
(
  input  wire logic [2:0] code,
  output logic      [8:0] beats
);

  always_comb
  begin
    if (code == 3'h0)
      beats = 9'h001;
    else
      beats = 9'(9'h002 << code);
  end

endmodule

/* File: dcd_channel.sv */
// Register access over APB and the placing of the registers were chosen for this implementation.
`include "dcd_defines.svh"

module dcd_channel
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             mem_req,
  output logic             mem_write,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  output logic      [2:0]  mem_size,
  output logic      [8:0]  mem_burst,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata
);

  // ========================================================
  // storage
  logic [31:0]          src_reg;
  logic [31:0]          dst_reg;
  logic [31:0]          next_reg;
  logic [31:0]          ctrl_reg;
  logic [1:0]           cfg_reg;
  logic [1:0]           status_reg;
  logic [1:0]           status_next;
  logic [1:0]           mask_reg;
  logic [31:0]          data_reg;
  logic [31:0]          base_reg;
  logic [1:0]           idx_reg;
  dcd_pkg::dcd_state_t  state_reg;
  dcd_pkg::dcd_state_t  state_next;

  // ========================================================
  // decode
  logic        setup;
  logic        wr_en;
  logic        mapped;
  logic [2:0]  dw;
  logic [2:0]  sw;
  logic [8:0]  dst_beats;
  logic [8:0]  src_beats;
  logic        width_bad;
  logic        unit_done;
  logic        last_unit;
  logic        fetch_done;
  logic        end_evt;
  logic        err_evt;
  logic [31:0] dst_step;
  logic [31:0] src_step;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign dw    = ctrl_reg[`DCD_CTRL_DW_MSB:`DCD_CTRL_DW_LSB];
  assign sw    = ctrl_reg[`DCD_CTRL_SW_MSB:`DCD_CTRL_SW_LSB];

  always_comb
  begin
    case (paddr)
      `DCD_OFS_SRC, `DCD_OFS_DST, `DCD_OFS_NEXT, `DCD_OFS_CTRL,
      `DCD_OFS_CFG, `DCD_OFS_STATUS, `DCD_OFS_MASK:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  // reserved width codes stop the channel
  assign width_bad = (dw > dcd_pkg::WD_WORD) | (sw > dcd_pkg::WD_WORD);
  assign dst_step  = 32'(32'h1 << dw);
  assign src_step  = 32'(32'h1 << sw);

  dcd_beat_decode u_dst_beats
  (
    .code  (ctrl_reg[`DCD_CTRL_DB_MSB:`DCD_CTRL_DB_LSB]),
    .beats (dst_beats)
  );

  dcd_beat_decode u_src_beats
  (
    .code  (ctrl_reg[`DCD_CTRL_SB_MSB:`DCD_CTRL_SB_LSB]),
    .beats (src_beats)
  );

  assign unit_done  = (state_reg == dcd_pkg::ST_WRITE) & mem_ack;
  assign last_unit  = ctrl_reg[`DCD_CTRL_CNT_MSB:`DCD_CTRL_CNT_LSB] == 12'h001;
  assign fetch_done = (state_reg == dcd_pkg::ST_FETCH) & mem_ack & (idx_reg == 2'h3);
  assign end_evt    = (state_reg == dcd_pkg::ST_END) & ctrl_reg[`DCD_CTRL_IRQ_EN]
                      & cfg_reg[`DCD_CFG_CEIM];
  assign err_evt    = (state_reg == dcd_pkg::ST_IDLE) & cfg_reg[`DCD_CFG_EN] & width_bad;

  // ========================================================
  // apb answer
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= `DCD_RST_WORD;
    else if (setup & ~pwrite)
    begin
      case (paddr)
        `DCD_OFS_SRC:    prdata <= src_reg;
        `DCD_OFS_DST:    prdata <= dst_reg;
        `DCD_OFS_NEXT:   prdata <= next_reg;
        `DCD_OFS_CTRL:   prdata <= ctrl_reg;
        `DCD_OFS_CFG:    prdata <= {30'h0, cfg_reg};
        `DCD_OFS_STATUS: prdata <= {30'h0, status_reg};
        `DCD_OFS_MASK:   prdata <= {30'h0, mask_reg};
        default:         prdata <= `DCD_RST_WORD;
      endcase
    end
  end

  // ========================================================
  // sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      dcd_pkg::ST_IDLE:
        if (cfg_reg[`DCD_CFG_EN] & ~width_bad)
        begin
          if (ctrl_reg[`DCD_CTRL_CNT_MSB:`DCD_CTRL_CNT_LSB] == 12'h000)
            state_next = dcd_pkg::ST_END;
          else
            state_next = dcd_pkg::ST_READ;
        end
      dcd_pkg::ST_READ:
        if (mem_ack)
          state_next = dcd_pkg::ST_WRITE;
      dcd_pkg::ST_WRITE:
        if (mem_ack)
          state_next = last_unit ? dcd_pkg::ST_END : dcd_pkg::ST_READ;
      dcd_pkg::ST_END:
        if (next_reg == `DCD_RST_WORD)
          state_next = dcd_pkg::ST_IDLE;
        else
          state_next = dcd_pkg::ST_FETCH;
      dcd_pkg::ST_FETCH:
        if (fetch_done)
          state_next = dcd_pkg::ST_IDLE;
      default:
        state_next = dcd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= dcd_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  // descriptor word index and base
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx_reg  <= 2'h0;
      base_reg <= `DCD_RST_WORD;
    end
    else if (state_reg == dcd_pkg::ST_END)
    begin
      idx_reg  <= 2'h0;
      base_reg <= next_reg;
    end
    else if ((state_reg == dcd_pkg::ST_FETCH) & mem_ack)
      idx_reg <= idx_reg + 2'h1;
  end

  // data held between read and write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      data_reg <= `DCD_RST_WORD;
    else if ((state_reg == dcd_pkg::ST_READ) & mem_ack)
      data_reg <= mem_rdata;
  end

  // ========================================================
  // memory request
  always_comb
  begin
    mem_req   = 1'b0;
    mem_write = 1'b0;
    mem_addr  = src_reg;
    mem_size  = sw;
    mem_burst = src_beats;
    case (state_reg)
      dcd_pkg::ST_READ:
        mem_req = 1'b1;
      dcd_pkg::ST_WRITE:
      begin
        mem_req   = 1'b1;
        mem_write = 1'b1;
        mem_addr  = dst_reg;
        mem_size  = dw;
        mem_burst = dst_beats;
      end
      dcd_pkg::ST_FETCH:
      begin
        mem_req   = 1'b1;
        mem_addr  = base_reg + {28'h0, idx_reg, 2'h0};
        mem_size  = dcd_pkg::WD_WORD;
        mem_burst = 9'h004;
      end
      default:
        mem_req = 1'b0;
    endcase
  end

  assign mem_wdata = data_reg;

  // ========================================================
  // address registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      src_reg <= `DCD_RST_WORD;
    else if ((state_reg == dcd_pkg::ST_FETCH) & mem_ack & (idx_reg == `DCD_DESC_SRC))
      src_reg <= mem_rdata;
    else if (unit_done & ctrl_reg[`DCD_CTRL_SRC_INC])
      src_reg <= src_reg + src_step;
    else if (wr_en & (paddr == `DCD_OFS_SRC))
      src_reg <= pwdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dst_reg <= `DCD_RST_WORD;
    else if ((state_reg == dcd_pkg::ST_FETCH) & mem_ack & (idx_reg == `DCD_DESC_DST))
      dst_reg <= mem_rdata;
    else if (unit_done & ctrl_reg[`DCD_CTRL_DST_INC])
      dst_reg <= dst_reg + dst_step;
    else if (wr_en & (paddr == `DCD_OFS_DST))
      dst_reg <= pwdata;
  end

  // ========================================================
  // next pointer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      next_reg <= `DCD_RST_WORD;
    else if ((state_reg == dcd_pkg::ST_FETCH) & mem_ack & (idx_reg == `DCD_DESC_NEXT))
      next_reg <= {mem_rdata[`DCD_NEXT_MSB:`DCD_NEXT_LSB], 2'h0};
    else if (wr_en & (paddr == `DCD_OFS_NEXT))
      next_reg <= {pwdata[`DCD_NEXT_MSB:`DCD_NEXT_LSB], 2'h0};
  end

  // ========================================================
  // control word, count runs down per unit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= `DCD_RST_WORD;
    else if ((state_reg == dcd_pkg::ST_FETCH) & mem_ack & (idx_reg == `DCD_DESC_CTRL))
      ctrl_reg <= mem_rdata & `DCD_CTRL_WMASK;
    else if (unit_done)
      ctrl_reg[`DCD_CTRL_CNT_MSB:`DCD_CTRL_CNT_LSB] <=
        ctrl_reg[`DCD_CTRL_CNT_MSB:`DCD_CTRL_CNT_LSB] - 12'h001;
    else if (wr_en & (paddr == `DCD_OFS_CTRL))
      ctrl_reg <= pwdata & `DCD_CTRL_WMASK;
  end

  // ========================================================
  // configuration: enable and end-interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_reg <= 2'h0;
    else if (((state_reg == dcd_pkg::ST_END) & (next_reg == `DCD_RST_WORD)) | err_evt)
      cfg_reg[`DCD_CFG_EN] <= 1'b0;
    else if (wr_en & (paddr == `DCD_OFS_CFG))
      cfg_reg <= pwdata[1:0];
  end

  // ========================================================
  // interrupt status, mask and output
  always_comb
  begin
    status_next = status_reg;
    if (wr_en & (paddr == `DCD_OFS_STATUS))
      status_next = status_next & ~pwdata[1:0];
    status_next[`DCD_ST_END] = status_next[`DCD_ST_END] | end_evt;
    status_next[`DCD_ST_ERR] = status_next[`DCD_ST_ERR] | err_evt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_reg <= `DCD_RST_STATUS;
    else
      status_reg <= status_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_reg <= 2'h0;
    else if (wr_en & (paddr == `DCD_OFS_MASK))
      mask_reg <= pwdata[1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(status_next & mask_reg);
  end

endmodule

/* File: dcd_mem.sv */
// ==========
// memory partner, answers promptly or after three stall cycles
module dcd_mem
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [8:0]  mem_burst,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata
);
  logic [31:0] words [0:63];
  logic [31:0] last_raddr;
  logic [31:0] last_waddr;
  logic [8:0]  rburst;
  logic [8:0]  wburst;
  logic [1:0]  wait_cnt;
  // known contents, so no unknown data reaches the write bus
  initial
  begin
    foreach (words[i])
      words[i] = 32'(i);
  end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_cnt <= 2'h0;
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && slow && wait_cnt != 2'h3)
        wait_cnt <= wait_cnt + 2'h1;
      else if (mem_req && !mem_ack)
      begin
        mem_ack <= 1'b1;
        wait_cnt <= 2'h0;
        if (mem_write)
        begin
          words[mem_addr[7:2]] <= mem_wdata;
          last_waddr <= mem_addr;
          wburst <= mem_burst;
        end
        else
        begin
          mem_rdata <= words[mem_addr[7:2]];
          last_raddr <= mem_addr;
          rburst <= mem_burst;
        end
      end
    end
  end
endmodule

/* File: dcd_channel_sva.sv */
module dcd_channel_sva
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        mem_req,
  input wire logic        mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [2:0]  mem_size,
  input wire logic [8:0]  mem_burst,
  input wire logic        mem_ack,
  input wire logic [31:0] mem_rdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ptr; psel && penable && !pwrite && paddr == 8'h08 |-> prdata[1:0] == 2'h0; endproperty
  a_ptr: assert property (p_ptr) else $error("pointer low bits");
  property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_write); endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_wdat; mem_req && mem_write && !mem_ack |=> $stable(mem_wdata) && $stable(mem_size); endproperty
  a_wdat: assert property (p_wdat) else $error("write data moved");
  property p_pair; mem_req && mem_write && mem_ack |=> !mem_write; endproperty
  a_pair: assert property (p_pair) else $error("write without read");
  property p_dsz; mem_req && mem_write |-> mem_size <= 3'h2; endproperty
  a_dsz: assert property (p_dsz) else $error("dest width");
  property p_ssz; mem_req && !mem_write |-> mem_size <= 3'h2; endproperty
  a_ssz: assert property (p_ssz) else $error("src width");
  property p_dbu; mem_req && mem_write |-> $onehot(mem_burst) && mem_burst != 9'h002; endproperty
  a_dbu: assert property (p_dbu) else $error("dest burst");
  property p_sbu; mem_req && !mem_write |-> $onehot(mem_burst) && mem_burst != 9'h002; endproperty
  a_sbu: assert property (p_sbu) else $error("src burst");
endmodule
bind dcd_channel dcd_channel_sva i_dcd_channel_sva (.*);

/* File: dcd_channel_test.sv */
module dcd_channel_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata, mem_addr, mem_wdata, mem_rdata;
  logic pready, pslverr, irq, mem_req, mem_write, mem_ack, err;
  logic [2:0] mem_size;
  logic [8:0] mem_burst;
  int fail_count = 0, checks_done = 0;
  typedef struct {logic [31:0] c, r, w; logic [8:0] wb, rb; logic i;} dcd_row_t;
  dcd_row_t rows [8] = '{
    '{32'h8C48_0002, 32'h104, 32'h204, 9'h001, 9'h001, 1'b1},
    '{32'h0C20_A002, 32'h101, 32'h202, 9'h004, 9'h008, 1'b0},
    '{32'h0C05_F002, 32'h102, 32'h201, 9'h010, 9'h100, 1'b0},
    '{32'h084A_3002, 32'h100, 32'h204, 9'h020, 9'h010, 1'b0},
    '{32'h044A_C002, 32'h104, 32'h200, 9'h040, 9'h020, 1'b0},
    '{32'h0C4B_5002, 32'h104, 32'h204, 9'h080, 9'h040, 1'b0},
    '{32'h8C4B_E002, 32'h104, 32'h204, 9'h100, 9'h080, 1'b1},
    '{32'h0C49_1002, 32'h104, 32'h204, 9'h008, 9'h004, 1'b0}};
  always #25 pclk = ~pclk;
  dcd_channel i_dcd_channel (.*);
  dcd_mem i_dcd_mem (.*);
  // ==========
  // shared tasks
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic go(input logic [31:0] s, t, nx, c, input logic [1:0] cf);
    int n;
    n = 0;
    apb(1, 8'h00, s);
    apb(1, 8'h04, t);
    apb(1, 8'h08, nx);
    apb(1, 8'h0C, c);
    apb(1, 8'h18, 32'h1);
    apb(1, 8'h10, {30'h0, cf});
    rd = 32'h1;
    while (rd[0] === 1'b1 && n < 100)
    begin
      n++;
      apb(0, 8'h10, 32'h0);
    end
    chk_bit("enable", 1'b0, rd[0]);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #2_000_000;
    fail_count++;
    tally_and_finish;
  end
  // ==========
  // main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[k])
    begin
      go(32'h100, 32'h200, 32'h0, rows[k].c, 2'h3);
      chk("src addr", rows[k].r, i_dcd_mem.last_raddr);
      chk("dst addr", rows[k].w, i_dcd_mem.last_waddr);
      chk("dst burst", {23'h0, rows[k].wb}, {23'h0, i_dcd_mem.wburst});
      chk("src burst", {23'h0, rows[k].rb}, {23'h0, i_dcd_mem.rburst});
      chk_bit("irq", rows[k].i, irq);
      apb(1, 8'h14, 32'h3);
      apb(0, 8'h14, 32'h0);
      chk_bit("irq clear", 1'b0, irq);
      $display("row %0d done", k);
    end
    go(32'h100, 32'h200, 32'h0, 32'h8C48_0002, 2'h1);
    chk_bit("irq unmasked cfg", 1'b0, irq);
    apb(1, 8'h08, 32'hFFFF_FFE3);
    apb(0, 8'h08, 32'h0);
    chk("next ptr", 32'hFFFF_FFE0, rd);
    apb(1, 8'h0C, 32'hFFFF_FFFF);
    apb(0, 8'h0C, 32'h0);
    chk("ctrl", 32'h8CFF_FFFF, rd);
    $display("register fields done");
    i_dcd_mem.words[16] = 32'h80;
    i_dcd_mem.words[17] = 32'hC0;
    i_dcd_mem.words[18] = 32'h0;
    i_dcd_mem.words[19] = 32'h8C48_0001;
    i_dcd_mem.words[32] = 32'hA5A5_0001;
    slow <= 1'b1;
    go(32'h90, 32'hD0, 32'h40, 32'h0C48_0001, 2'h3);
    chk("dst addr", 32'hC0, i_dcd_mem.last_waddr);
    chk("data", 32'hA5A5_0001, i_dcd_mem.words[48]);
    apb(0, 8'h0C, 32'h0);
    chk("ctrl", 32'h8C48_0000, rd);
    apb(0, 8'h08, 32'h0);
    chk("next ptr", 32'h0, rd);
    chk_bit("irq", 1'b1, irq);
    apb(1, 8'h18, 32'h0);
    apb(0, 8'h14, 32'h0);
    chk_bit("irq masked", 1'b0, irq);
    apb(1, 8'h14, 32'h3);
    slow <= 1'b0;
    $display("chain done");
    apb(0, 8'h1C, 32'h0);
    chk_bit("slverr", 1'b1, err);
    chk("unmapped", 32'h0, rd);
    go(32'h100, 32'h200, 32'h0, 32'h0C68_0002, 2'h3);
    apb(0, 8'h14, 32'h0);
    chk("status", 32'h2, rd);
    apb(1, 8'h14, 32'h3);
    go(32'h100, 32'h200, 32'h0, 32'h0C4C_0002, 2'h3);
    apb(0, 8'h14, 32'h0);
    chk("status", 32'h2, rd);
    $display("errors done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h08, 32'h0);
    chk("next rst", 32'h0, rd);
    apb(0, 8'h0C, 32'h0);
    chk("ctrl rst", 32'h0, rd);
    $display("reset done");
    tally_and_finish;
  end
endmodule
